// File: fast_pwm_timer.sv
// Top of the 10-bit fast PWM timer: register port, counter, compares, outputs, fault logic.
// Assumes the timer tick comes from an outside prescaler as a one-cycle enable,
// and that the CPU interrupt and flag-register logic sit outside this block.
`timescale 1ns/10ps
module fast_pwm_timer
   import pwm_timer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire io_req_t io_req,
   output logic [7:0] io_rdata,
   input wire logic tmr_tick,
   input wire logic channel_pwm_enable,
   input wire logic global_irq_enable,
   input wire logic fault_vector_taken,
   input wire logic fault_input_pin,
   input wire logic comparator_out,
   input wire logic wave_d,
   input wire logic [1:0] compare_flag_clear,
   input wire logic overflow_flag_clear,
   input wire logic [SIX_OUT-1:0] port_value,
   output logic [SIX_OUT-1:0] pwm_pin,
   output logic [1:0] compare_flag,
   output logic overflow_flag,
   output logic fault_flag,
   output logic fault_irq
);
   logic [7:0] ctrl_q;
   logic [SIX_OUT-1:0] override_q;
   logic [1:0] temp_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   count_dir_t dir_q;
   count_dir_t dir_d;
   logic [CNT_WR_DELAY-1:0] cnt_wr_pend_q;
   logic [CNT_W-1:0] cnt_wr_val_q;
   logic [CNT_W-1:0] top_buf_q;
   logic [CNT_W-1:0] top_act_q;
   logic step;
   logic ovf_evt;
   logic update_evt;
   logic ovf_clr_q;
   logic ovf_q;
   logic fault_src;
   logic fault_evt;
   logic fault_clr_q;
   logic fault_flag_q;
   logic [SIX_OUT-1:0] wave_q;
   logic [SIX_OUT-1:0] pin_q;
   logic [1:0] cmp_wr;
   logic [CNT_W-1:0] cmp_buf [2];
   logic [CNT_W-1:0] cmp_act [2];
   wave_mode_t wave_mode;
   logic pwm_on;
   logic dual_slope;
   logic six_out;
   logic outputs_blocked;
   logic [CNT_W-1:0] wr_word;

   // A write strobe aimed at one register address
   function automatic logic wr_hit(input io_req_t req, input logic [5:0] addr);
      wr_hit = req.wr && (req.addr == addr);
   endfunction : wr_hit

   // A read strobe aimed at one register address
   function automatic logic rd_hit(input io_req_t req, input logic [5:0] addr);
      rd_hit = req.rd && (req.addr == addr);
   endfunction : rd_hit

   // Clamp a TOP value to the smallest legal one
   function automatic logic [CNT_W-1:0] clamp_top(input logic [CNT_W-1:0] val);
      clamp_top = (val < TOP_MIN) ? TOP_MIN : val;
   endfunction : clamp_top

   // Mode decode; without PWM the mode bits are ignored
   assign wave_mode = wave_mode_t'({ctrl_q[FW_WGM_HI], ctrl_q[FW_WGM_LO]});
   assign pwm_on = channel_pwm_enable;
   assign dual_slope = pwm_on && ((wave_mode == MODE_PHASE_FREQ) || (wave_mode == MODE_SIX_DUAL));
   assign six_out = pwm_on && ((wave_mode == MODE_SIX_SINGLE) || (wave_mode == MODE_SIX_DUAL));
   assign wr_word = {temp_q, io_req.wdata};

   // Control register; the flag bit is not stored here, writing one asks for a clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= REG_RESET;
      end else if (wr_hit(io_req, ADDR_FAULT_WAVE)) begin
         ctrl_q <= io_req.wdata & ~(8'h01 << FW_FLAG);
      end
   end

   // Override enables, six bits only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         override_q <= OVR_RESET;
      end else if (wr_hit(io_req, ADDR_OVERRIDE)) begin
         override_q <= io_req.wdata[SIX_OUT-1:0];
      end
   end

   // Shared high-byte temp: written by software, or loaded when a low byte is read
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         temp_q <= TEMP_RESET;
      end else if (wr_hit(io_req, ADDR_HIGH_TEMP)) begin
         temp_q <= io_req.wdata[1:0];
      end else if (rd_hit(io_req, ADDR_COUNTER)) begin
         temp_q <= cnt_q[CNT_W-1:8];
      end else if (rd_hit(io_req, ADDR_CMP_A)) begin
         temp_q <= cmp_buf[0][CNT_W-1:8];
      end else if (rd_hit(io_req, ADDR_CMP_B)) begin
         temp_q <= cmp_buf[1][CNT_W-1:8];
      end else if (rd_hit(io_req, ADDR_CMP_TOP)) begin
         temp_q <= top_buf_q[CNT_W-1:8];
      end
   end

   // Read mux; unmapped addresses and reserved bits read as zero
   always_comb begin
      rdata_d = 8'h00;
      unique case (io_req.addr)
         ADDR_HIGH_TEMP: rdata_d = {6'h00, temp_q};
         ADDR_FAULT_WAVE: rdata_d = {ctrl_q[7:3], fault_flag_q, ctrl_q[1:0]};
         ADDR_OVERRIDE: rdata_d = {2'h0, override_q};
         ADDR_COUNTER: rdata_d = cnt_q[7:0];
         ADDR_CMP_A: rdata_d = cmp_buf[0][7:0];
         ADDR_CMP_B: rdata_d = cmp_buf[1][7:0];
         ADDR_CMP_TOP: rdata_d = top_buf_q[7:0];
         default: rdata_d = 8'h00;
      endcase
   end

   // Read data is registered and holds until the next read
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (io_req.rd) begin
         rdata_q <= rdata_d;
      end
   end
   assign io_rdata = rdata_q;

   // Counter writes pass a short pipe, mimicking the CPU-to-timer sync delay
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_wr_pend_q <= '0;
         cnt_wr_val_q <= CNT_BOTTOM;
      end else begin
         cnt_wr_pend_q <= {cnt_wr_pend_q[CNT_WR_DELAY-2:0], wr_hit(io_req, ADDR_COUNTER)};
         if (wr_hit(io_req, ADDR_COUNTER)) begin
            cnt_wr_val_q <= wr_word;
         end
      end
   end

   // Next counter value; a pending write beats the tick
   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      step = 1'b0;
      ovf_evt = 1'b0;
      update_evt = 1'b0;
      if (cnt_wr_pend_q[CNT_WR_DELAY-1]) begin
         cnt_d = cnt_wr_val_q;
         dir_d = DIR_UP;
      end else if (tmr_tick) begin
         step = 1'b1;
         if (!dual_slope) begin
            if (cnt_q == top_act_q) begin
               cnt_d = CNT_BOTTOM;
               ovf_evt = 1'b1;
               update_evt = 1'b1;
            end else begin
               cnt_d = cnt_q + CNT_ONE;
            end
         end else begin
            unique case (dir_q)
               DIR_UP: begin
                  if (cnt_q >= top_act_q) begin
                     dir_d = DIR_DOWN;
                     cnt_d = cnt_q - CNT_ONE;
                  end else begin
                     cnt_d = cnt_q + CNT_ONE;
                  end
               end
               DIR_DOWN: begin
                  if (cnt_q == CNT_BOTTOM) begin
                     dir_d = DIR_UP;
                     cnt_d = CNT_ONE;
                  end else begin
                     cnt_d = cnt_q - CNT_ONE;
                     if (cnt_q == CNT_ONE) begin
                        dir_d = DIR_UP;
                        ovf_evt = 1'b1;
                        update_evt = 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Counter state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= CNT_BOTTOM;
         dir_q <= DIR_UP;
      end else begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
      end
   end

   // TOP register: clamped on write, active copy updated at once or at the update point
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         top_buf_q <= TOP_RESET;
         top_act_q <= TOP_RESET;
      end else begin
         if (wr_hit(io_req, ADDR_CMP_TOP)) begin
            top_buf_q <= clamp_top(wr_word);
         end
         if (!pwm_on || update_evt) begin
            top_act_q <= top_buf_q;
         end
      end
   end

   // Overflow flag; the set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ovf_clr_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         ovf_clr_q <= overflow_flag_clear;
         if (ovf_evt) begin
            ovf_q <= 1'b1;
         end else if (ovf_clr_q) begin
            ovf_q <= 1'b0;
         end
      end
   end

   // Compare channels A and B
   assign cmp_wr[0] = wr_hit(io_req, ADDR_CMP_A);
   assign cmp_wr[1] = wr_hit(io_req, ADDR_CMP_B);
   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
         compare_channel u_cmp (
            .sys_clk(sys_clk),
            .rst(rst),
            .wr_en(cmp_wr[ch]),
            .wr_val(wr_word),
            .immediate(!pwm_on),
            .load(update_evt),
            .step(step),
            .cnt_next(cnt_d),
            .flag_clear(compare_flag_clear[ch]),
            .buf_val(cmp_buf[ch]),
            .act_val(cmp_act[ch]),
            .flag(compare_flag[ch])
         );
      end
   endgenerate

   // Fault source: the comparator output when selected, else the pin level sampled whatever its port direction
   assign fault_src = ctrl_q[FW_CMP] ? comparator_out : fault_input_pin;

   fault_front_end u_fault (
      .sys_clk(sys_clk),
      .rst(rst),
      .sample_in(fault_src),
      .filter_en(ctrl_q[FW_FILTER]),
      .rise_sel(ctrl_q[FW_EDGE]),
      .edge_evt(fault_evt)
   );

   // Fault flag: set by a qualified event, cleared by the vector or a delayed write-one
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fault_clr_q <= 1'b0;
         fault_flag_q <= 1'b0;
      end else begin
         fault_clr_q <= wr_hit(io_req, ADDR_FAULT_WAVE) && io_req.wdata[FW_FLAG];
         if (fault_evt && ctrl_q[FW_MODE_EN]) begin
            fault_flag_q <= 1'b1;
         end else if (fault_clr_q || fault_vector_taken) begin
            fault_flag_q <= 1'b0;
         end
      end
   end
   assign fault_irq = global_irq_enable && ctrl_q[FW_IRQ_EN] && fault_flag_q;

   // An active fault pulls the PWM drive off the pins while the flag is set and fault mode stays enabled
   assign outputs_blocked = ctrl_q[FW_MODE_EN] && fault_flag_q;

   // Waveforms: A and B high while the counter is below the compare value, in both slopes; odd bits are the complements
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wave_q <= '0;
      end else begin
         wave_q <= {~wave_d, wave_d, ~(cnt_q < cmp_act[1]), cnt_q < cmp_act[1],
                    ~(cnt_q < cmp_act[0]), cnt_q < cmp_act[0]};
      end
   end

   // Pin selection per output; a cleared override shows the port value one clock later, through the pin register
   generate
      for (genvar p = 0; p < SIX_OUT; p++) begin : g_pin
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               pin_q[p] <= 1'b0;
            end else begin
               pin_q[p] <= (six_out && override_q[p] && !outputs_blocked) ? wave_q[p] : port_value[p];
            end
         end
      end
   endgenerate

   assign pwm_pin = pin_q;
   assign overflow_flag = ovf_q;
   assign fault_flag = fault_flag_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   property p_irq_gate;
      fault_irq |-> (global_irq_enable && ctrl_q[FW_IRQ_EN] && fault_flag_q);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("fault irq without all enables");

   property p_fault_sets_flag;
      (fault_evt && ctrl_q[FW_MODE_EN]) |=> fault_flag_q;
   endproperty
   a_fault_sets_flag: assert property (p_fault_sets_flag) else $error("fault event lost");

   property p_no_flag_when_off;
      (!fault_flag_q && !ctrl_q[FW_MODE_EN]) |=> !fault_flag_q;
   endproperty
   a_no_flag_when_off: assert property (p_no_flag_when_off) else $error("flag set while off");

   sequence s_flag_clear_write;
      wr_hit(io_req, ADDR_FAULT_WAVE) && io_req.wdata[FW_FLAG] && !fault_evt;
   endsequence
   property p_flag_clears;
      s_flag_clear_write ##1 !fault_evt |=> !fault_flag_q;
   endproperty
   a_flag_clears: assert property (p_flag_clears) else $error("fault flag not cleared");

   sequence s_counter_write;
      wr_hit(io_req, ADDR_COUNTER);
   endsequence
   property p_counter_write;
      s_counter_write ##1 !wr_hit(io_req, ADDR_COUNTER) ##1 1'b1 |=> (cnt_q == $past(wr_word, 3)) && (dir_q == DIR_UP);
   endproperty
   a_counter_write: assert property (p_counter_write) else $error("counter write wrong");

   property p_top_min;
      top_buf_q >= TOP_MIN;
   endproperty
   a_top_min: assert property (p_top_min) else $error("top below minimum");

   property p_top_wrap;
      (step && !dual_slope && cnt_q == top_act_q) |=> (cnt_q == CNT_BOTTOM) && ovf_q;
   endproperty
   a_top_wrap: assert property (p_top_wrap) else $error("no wrap at top");

   property p_reserved_zero;
      rd_hit(io_req, ADDR_OVERRIDE) || rd_hit(io_req, ADDR_HIGH_TEMP) |=> io_rdata[7:6] == 2'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   property p_override_off;
      (!override_q[0]) |=> pin_q[0] == $past(port_value[0]);
   endproperty
   a_override_off: assert property (p_override_off) else $error("pin not port value");
endmodule : fast_pwm_timer

// File: pwm_timer_pkg.sv
// Shared constants and types for the 10-bit fast PWM timer with fault protection.
// Assumes an 8-bit register port with 6-bit addresses and one 40 MHz system clock.
package pwm_timer_pkg;
   localparam int unsigned CNT_W = 10;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned SIX_OUT = 6;
   // Register addresses on the 8-bit register port
   localparam logic [5:0] ADDR_HIGH_TEMP = 6'h25;
   localparam logic [5:0] ADDR_FAULT_WAVE = 6'h26;
   localparam logic [5:0] ADDR_COUNTER = 6'h2E;
   localparam logic [5:0] ADDR_OVERRIDE = 6'h20;
   localparam logic [5:0] ADDR_CMP_A = 6'h2D;
   localparam logic [5:0] ADDR_CMP_B = 6'h2C;
   localparam logic [5:0] ADDR_CMP_TOP = 6'h2B;
   // Bit positions in fault_and_wave_control
   localparam int unsigned FW_IRQ_EN = 7;
   localparam int unsigned FW_MODE_EN = 6;
   localparam int unsigned FW_FILTER = 5;
   localparam int unsigned FW_EDGE = 4;
   localparam int unsigned FW_CMP = 3;
   localparam int unsigned FW_FLAG = 2;
   localparam int unsigned FW_WGM_HI = 1;
   localparam int unsigned FW_WGM_LO = 0;
   // Reset values and limits
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] TEMP_RESET = 2'h0;
   localparam logic [5:0] OVR_RESET = 6'h00;
   localparam logic [9:0] CNT_BOTTOM = 10'h000;
   localparam logic [9:0] CNT_ONE = 10'h001;
   localparam logic [9:0] CMP_RESET = 10'h000;
   localparam logic [9:0] TOP_RESET = 10'h0FF;
   localparam logic [9:0] TOP_MIN = 10'h003;
   // Timing: samples for the noise filter, counter write delay in half CPU cycles
   localparam int unsigned FILTER_LEN = 4;
   localparam int unsigned CNT_WR_HALF_CYCLES = 3;
   localparam int unsigned CNT_WR_DELAY = (CNT_WR_HALF_CYCLES + 1) / 2;
   typedef enum logic [1:0] {MODE_FAST, MODE_PHASE_FREQ, MODE_SIX_SINGLE, MODE_SIX_DUAL} wave_mode_t;
   typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } io_req_t;
endpackage : pwm_timer_pkg

// File: fault_front_end.sv
// Fault input front end: optional four-sample noise filter and edge selection.
// Assumes the sampled source is already synchronous to sys_clk.
`timescale 1ns/10ps
module fault_front_end
   import pwm_timer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic sample_in,
   input wire logic filter_en,
   input wire logic rise_sel,
   output logic edge_evt
);
   logic [FILTER_LEN-1:0] hist_q;
   logic filt_q;
   logic filt_prev_q;

   // Sample history, newest in bit 0
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hist_q <= '0;
      end else begin
         hist_q <= {hist_q[FILTER_LEN-2:0], sample_in};
      end
   end

   // Filtered level moves only on a full run of equal samples, so a glitch is dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         filt_q <= 1'b0;
      end else if (!filter_en) begin
         filt_q <= sample_in;
      end else if (&hist_q) begin
         filt_q <= 1'b1;
      end else if (~|hist_q) begin
         filt_q <= 1'b0;
      end
   end

   // Edge detect on the filtered level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         filt_prev_q <= 1'b0;
      end else begin
         filt_prev_q <= filt_q;
      end
   end
   assign edge_evt = rise_sel ? (filt_q & ~filt_prev_q) : (~filt_q & filt_prev_q);

   property p_filter_needs_run;
      @(posedge sys_clk) disable iff (rst)
      (filter_en && $past(filter_en) && $changed(filt_q)) |-> (filt_q ? &$past(hist_q) : ~|$past(hist_q));
   endproperty
   a_filter_needs_run: assert property (p_filter_needs_run) else $error("filter moved early");
endmodule : fault_front_end

// File: compare_channel.sv
// One buffered compare channel: software buffer, active value, match and flag.
// Assumes the owner tells it when the counter steps and when buffers may load.
`timescale 1ns/10ps
module compare_channel
   import pwm_timer_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [CNT_W-1:0] wr_val,
   input wire logic immediate,
   input wire logic load,
   input wire logic step,
   input wire logic [CNT_W-1:0] cnt_next,
   input wire logic flag_clear,
   output logic [CNT_W-1:0] buf_val,
   output logic [CNT_W-1:0] act_val,
   output logic flag
);
   logic [CNT_W-1:0] buf_q;
   logic [CNT_W-1:0] act_q;
   logic match_q;
   logic clr_q;
   logic flag_q;

   // Software buffer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         buf_q <= CMP_RESET;
      end else if (wr_en) begin
         buf_q <= wr_val;
      end
   end

   // Active value follows the buffer at once, or only at the update point
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         act_q <= CMP_RESET;
      end else if (immediate || load) begin
         act_q <= buf_q;
      end
   end

   // Match only when the counter steps onto the value, never on a write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         match_q <= 1'b0;
      end else begin
         match_q <= step && (cnt_next == act_q);
      end
   end

   // Flag set one sync cycle after the match; a set beats a clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clr_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         clr_q <= flag_clear;
         if (match_q) begin
            flag_q <= 1'b1;
         end else if (clr_q) begin
            flag_q <= 1'b0;
         end
      end
   end

   assign buf_val = buf_q;
   assign act_val = act_q;
   assign flag = flag_q;

   sequence s_step_onto;
      step && (cnt_next == act_q);
   endsequence
   property p_match_sets_flag;
      @(posedge sys_clk) disable iff (rst)
      s_step_onto |=> ##1 flag_q;
   endproperty
   a_match_sets_flag: assert property (p_match_sets_flag) else $error("match lost");
   property p_no_match_idle;
      @(posedge sys_clk) disable iff (rst)
      (!step && !match_q && !flag_q) |=> ##1 !flag_q;
   endproperty
   a_no_match_idle: assert property (p_no_match_idle) else $error("match without step");
endmodule : compare_channel

// File: power_stage_model.sv
// Model of the external power stage that pulls the fault line when it trips.
// Assumes a pull-up on the fault line and a trip command from the bench.
`timescale 1ns/10ps
module power_stage_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic trip,
   output logic fault_level
);
   // Line idles high through the pull-up, so only a trip or its release makes an edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fault_level <= 1'b1;
      end else begin
         fault_level <= !trip;
      end
   end
endmodule : power_stage_model

// File: testbench.sv
// Self-checking bench for the fast PWM timer: registers, counter, compares, fault.
// Assumes the 40 MHz clock, the strobe register port and the power stage model.
`timescale 1ns/10ps
module testbench
   import pwm_timer_pkg::*;
;
   `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
      $display("BAD t=%0t got %0h exp %0h", $time, a, e); end end
   logic sys_clk, rst, tmr_tick, gie, vec, trip, fault_pin, cmp_out, pwm_en, ovf_clr;
   logic [1:0] cmp_clr;
   io_req_t io_req;
   logic [7:0] io_rdata;
   logic [5:0] port_value, pwm_pin;
   logic [1:0] compare_flag;
   logic overflow_flag, fault_flag, fault_irq;
   int fail_count, n_compared, cycles;
   // Channel D waveform stays low; it lives outside this block
   fast_pwm_timer dut (.sys_clk(sys_clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
      .tmr_tick(tmr_tick), .channel_pwm_enable(pwm_en), .global_irq_enable(gie),
      .fault_vector_taken(vec), .fault_input_pin(fault_pin), .comparator_out(cmp_out),
      .wave_d(1'b0), .compare_flag_clear(cmp_clr), .overflow_flag_clear(ovf_clr),
      .port_value(port_value), .pwm_pin(pwm_pin), .compare_flag(compare_flag),
      .overflow_flag(overflow_flag), .fault_flag(fault_flag), .fault_irq(fault_irq));
   power_stage_model ps (.sys_clk(sys_clk), .rst(rst), .trip(trip), .fault_level(fault_pin));
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk) #1 io_req = '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk) #1 io_req.wr = 1'b0;
   endtask : wr
   // Read data is registered, so it is judged one edge after the strobe
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge sys_clk) #1 io_req = '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk) #1 io_req.rd = 1'b0;
      `CHK(io_rdata, e)
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : idle
   task automatic reset_values;
      rd(ADDR_HIGH_TEMP, 8'h00);
      rd(ADDR_COUNTER, 8'h00);
      rd(ADDR_CMP_TOP, 8'hFF);
      wr(ADDR_OVERRIDE, 8'hFF);
      rd(ADDR_OVERRIDE, 8'h3F);
      `CHK(pwm_pin, 6'h2A)
      wr(ADDR_HIGH_TEMP, 8'hFF);
      rd(ADDR_HIGH_TEMP, 8'h03);
      wr(ADDR_HIGH_TEMP, 8'h00);
      wr(ADDR_CMP_TOP, 8'h01);
      rd(ADDR_CMP_TOP, 8'h03);
      $display("test reset_values done");
   endtask : reset_values
   task automatic counter_access;
      wr(ADDR_HIGH_TEMP, 8'h02);
      wr(ADDR_COUNTER, 8'h34);
      idle(3);
      // Clear the temp so the read below must reload bits 9:8
      wr(ADDR_HIGH_TEMP, 8'h00);
      rd(ADDR_COUNTER, 8'h34);
      rd(ADDR_HIGH_TEMP, 8'h02);
      $display("test counter_access done");
   endtask : counter_access
   task automatic compare_top;
      wr(ADDR_HIGH_TEMP, 8'h00);
      wr(ADDR_CMP_TOP, 8'h05);
      wr(ADDR_CMP_A, 8'h02);
      wr(ADDR_CMP_B, 8'h04);
      wr(ADDR_COUNTER, 8'h02);
      idle(4);
      `CHK(compare_flag, 2'b00)
      wr(ADDR_COUNTER, 8'h00);
      idle(3);
      // Eight steps from zero with TOP five wrap once and land on two
      tmr_tick = 1'b1;
      idle(8);
      tmr_tick = 1'b0;
      idle(3);
      `CHK(compare_flag[0], 1'b1)
      `CHK(compare_flag[1], 1'b1)
      `CHK(overflow_flag, 1'b1)
      rd(ADDR_COUNTER, 8'h02);
      // Write-one clears land one sync cycle after the pulse
      cmp_clr = 2'b11;
      ovf_clr = 1'b1;
      idle(1);
      cmp_clr = 2'b00;
      ovf_clr = 1'b0;
      idle(1);
      `CHK(compare_flag, 2'b00)
      `CHK(overflow_flag, 1'b0)
      $display("test compare_top done");
   endtask : compare_top
   task automatic fault_trip;
      wr(ADDR_FAULT_WAVE, 8'hC0);
      gie = 1'b1;
      trip = 1'b1;
      idle(6);
      `CHK(fault_flag, 1'b1)
      `CHK(fault_irq, 1'b1)
      gie = 1'b0;
      #1 `CHK(fault_irq, 1'b0)
      vec = 1'b1;
      idle(1);
      vec = 1'b0;
      idle(1);
      `CHK(fault_flag, 1'b0)
      trip = 1'b0;
      idle(6);
      `CHK(fault_flag, 1'b0)
      // Filter on, rising edge, irq enable off: the flag still sets, later
      wr(ADDR_FAULT_WAVE, 8'h70);
      gie = 1'b1;
      trip = 1'b1;
      idle(8);
      `CHK(fault_flag, 1'b0)
      trip = 1'b0;
      idle(5);
      `CHK(fault_flag, 1'b0)
      idle(3);
      `CHK(fault_flag, 1'b1)
      `CHK(fault_irq, 1'b0)
      wr(ADDR_FAULT_WAVE, 8'h74);
      `CHK(fault_flag, 1'b1)
      idle(1);
      `CHK(fault_flag, 1'b0)
      rd(ADDR_FAULT_WAVE, 8'h70);
      // Comparator drives the front end; pin edges are then ignored
      cmp_out = 1'b1;
      wr(ADDR_FAULT_WAVE, 8'h48);
      trip = 1'b1;
      idle(4);
      `CHK(fault_flag, 1'b0)
      cmp_out = 1'b0;
      idle(3);
      `CHK(fault_flag, 1'b1)
      $display("test fault_trip done");
   endtask : fault_trip
   // Counter parked at two, A at two, B at four: pins show A low, B high, D low
   task automatic six_output;
      pwm_en = 1'b1;
      wr(ADDR_FAULT_WAVE, 8'h02);
      wr(ADDR_OVERRIDE, 8'hFF);
      idle(2);
      `CHK(pwm_pin, 6'h26)
      wr(ADDR_OVERRIDE, 8'h00);
      idle(2);
      `CHK(pwm_pin, 6'h2A)
      $display("test six_output done");
   endtask : six_output
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Whole run needs about 130 cycles; the ceiling leaves ample margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      {rst, tmr_tick, gie, vec, trip, cmp_out, pwm_en, ovf_clr} = 8'h80;
      cmp_clr = 2'b00;
      io_req = '0;
      port_value = 6'h2A;
      repeat (5) @(posedge sys_clk);
      #1 rst = 1'b0;
      reset_values();
      counter_access();
      compare_top();
      fault_trip();
      six_output();
      complete_run();
   end
endmodule : testbench
